// File: verilog/mai_pkg.sv
// Shared constants, format codes and framing helpers for the audio input link.
// Assumes both link ends and the register slave import this package.
package mai_pkg;
   localparam int          NUM_LANES    = 3;
   localparam int          NUM_CH       = 6;
   localparam int          SMP_W        = 24;
   localparam int          RATIO_W      = 12;
   localparam int          ADDR_W       = 8;
   localparam int          SCLK_HALF    = 2;
   localparam int          FMT_LSB      = 0;
   localparam int          FMT_W        = 3;
   localparam int          WL_LSB       = 4;
   localparam logic [7:0]  MISC_RST     = 8'h01;
   localparam logic [4:0]  SLOT_LAST    = 5'h1F;
   localparam logic [7:0]  FRAME_STEREO = 8'h40;
   localparam logic [7:0]  FRAME_MULTI  = 8'hC0;
   localparam logic [7:0]  FRAME_HALF   = 8'h60;
   localparam logic [7:0]  REG_CTRL     = 8'h00;
   localparam logic [7:0]  REG_MISC     = 8'h04;
   localparam logic [7:0]  REG_STAT     = 8'h08;
   localparam logic [7:0]  REG_SMP0     = 8'h10;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;

   typedef enum logic [2:0] {FMT_LJ, FMT_I2S, FMT_RJ, FMT_OL1, FMT_OL2, FMT_TDM} mai_fmt_e;

   function automatic mai_fmt_e fmt_of(input logic [7:0] cfg);
      logic [2:0] c;
      c = cfg[FMT_LSB +: FMT_W];
      // Codes above the last format fall back to I2S
      return (c > 3'h5) ? FMT_I2S : mai_fmt_e'(c);
   endfunction

   function automatic logic [4:0] wl_of(input logic [7:0] cfg);
      logic [1:0] c;
      c = cfg[WL_LSB +: 2];
      return (c == 2'h1) ? 5'h14 : (c == 2'h2) ? 5'h10 : 5'h18;
   endfunction

   function automatic logic multi_of(input mai_fmt_e f);
      return (f == FMT_OL1) || (f == FMT_OL2) || (f == FMT_TDM);
   endfunction

   function automatic logic left_lvl(input mai_fmt_e f);
      return (f == FMT_I2S) ? 1'b0 : 1'b1;
   endfunction

   function automatic logic [4:0] start_of(input mai_fmt_e f, input logic [4:0] wl);
      if ((f == FMT_I2S) || (f == FMT_OL2))
         return 5'h01;
      else if (f == FMT_RJ)
         return 5'(6'h20 - {1'b0, wl});
      else
         return 5'h00;
   endfunction

   function automatic logic in_win(input logic [4:0] pos, input logic [4:0] st,
                                   input logic [4:0] wl);
      return ({1'b0, pos} >= {1'b0, st}) && ({1'b0, pos} < ({1'b0, st} + {1'b0, wl}));
   endfunction
endpackage

// File: verilog/mai_link_if.sv
// Serial audio link between the processor end and the input port end.
// Assumes the processor end drives every wire; the input end only listens.
`timescale 1ns/10ps
interface mai_link_if;
   logic       frame_clock_in;
   logic       bit_clock_in;
   logic       audio_master_clock_in;
   logic       serial_data_in_1;
   logic       serial_data_in_2;
   logic       serial_data_in_3;
   logic [7:0] misc_configuration;

   modport dev (input frame_clock_in, input bit_clock_in, input audio_master_clock_in,
                input serial_data_in_1, input serial_data_in_2, input serial_data_in_3,
                input misc_configuration);
   modport host (output frame_clock_in, output bit_clock_in, output audio_master_clock_in,
                 output serial_data_in_1, output serial_data_in_2, output serial_data_in_3,
                 output misc_configuration);
endinterface

// File: verilog/mai_ratio.sv
// Master-clock to frame-clock ratio detector, running on the master clock.
// Assumes the frame clock is derived from the master clock but arrives unsynchronised.
`timescale 1ns/10ps
module mai_ratio
  #(parameter int RATIO_W = mai_pkg::RATIO_W)
  (
   input  logic               mclk,
   input  logic               aresetn,
   input  logic               frame_clock_in,
   output logic [RATIO_W-1:0] ratio,
   output logic               locked
  );
   import mai_pkg::*;

   logic               rst_s1_r;
   logic               rst_s2_r;
   logic               fr_s1_r;
   logic               fr_s2_r;
   logic               fr_d_r;
   logic               rise;
   logic [RATIO_W-1:0] cnt_r;
   logic [RATIO_W-1:0] ratio_r;
   logic               locked_r;

   always_ff @(posedge mclk or negedge aresetn)
   begin
      if (!aresetn)
         {rst_s1_r, rst_s2_r} <= 2'b00;
      else
         {rst_s1_r, rst_s2_r} <= {1'b1, rst_s1_r};
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_s2_r)
      begin
         fr_s1_r <= 1'b0;
         fr_s2_r <= 1'b0;
         fr_d_r  <= 1'b0;
      end
      else
      begin
         fr_s1_r <= frame_clock_in;
         fr_s2_r <= fr_s1_r;
         fr_d_r  <= fr_s2_r;
      end
   end

   assign rise = fr_s2_r & ~fr_d_r;

   // Saturates so a stopped frame clock never wraps into a false ratio
   always_ff @(posedge mclk)
   begin
      if (!rst_s2_r)
         cnt_r <= '0;
      else if (rise)
         cnt_r <= RATIO_W'(1);
      else if (cnt_r != '1)
         cnt_r <= cnt_r + RATIO_W'(1);
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_s2_r)
      begin
         ratio_r  <= '0;
         locked_r <= 1'b0;
      end
      else if (rise)
      begin
         ratio_r  <= cnt_r;
         locked_r <= (cnt_r == ratio_r) && (cnt_r != '1);
      end
   end

   assign ratio  = ratio_r;
   assign locked = locked_r;
endmodule // mai_ratio

// File: verilog/mai_host.sv
// Processor end of the audio link: drives clocks, framing and serial data.
// Assumes an AXI4-Lite master on aclk loads the channel samples and format.
`timescale 1ns/10ps
module mai_host
  #(parameter int SCLK_HALF = mai_pkg::SCLK_HALF)
  (
   input  logic                       aclk,
   input  logic                       aresetn,
   mai_link_if.host                   link,
   input  logic [mai_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  logic                       s_axi_awvalid,
   output logic                       s_axi_awready,
   input  logic [31:0]                s_axi_wdata,
   input  logic [3:0]                 s_axi_wstrb,
   input  logic                       s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  logic                       s_axi_bready,
   input  logic [mai_pkg::ADDR_W-1:0] s_axi_araddr,
   input  logic                       s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  logic                       s_axi_rready
  );
   import mai_pkg::*;

   localparam logic [3:0] DIV_LAST = 4'(SCLK_HALF - 1);

   logic              awrdy_r, wrdy_r, aw_have_r, w_have_r, bvalid_r, wr_fire;
   logic              arrdy_r, rvalid_r, en_r, mclk_r, sclk_r, lr_r, fall, lr_nxt;
   logic [1:0]        bresp_r, rresp_r;
   logic [ADDR_W-1:0] awaddr_r;
   logic [31:0]       wdata_r, rdata_r;
   logic [3:0]        wstrb_r, div_r;
   logic [7:0]        misc_r, bit_r, bit_nxt, fb;
   logic [15:0]       frames_r;
   logic [2:0]        sd_r, sd_nxt;
   logic [SMP_W-1:0]  smp_r [NUM_CH];
   logic [SMP_W-1:0]  tx_r  [NUM_CH];
   logic [SMP_W-1:0]  word;
   logic [2:0]        ch;
   mai_fmt_e          fmt;
   logic [4:0]        wl, st;

   function automatic logic [ADDR_W-1:0] smp_addr(input int c);
      return ADDR_W'(REG_SMP0 + 4 * c);
   endfunction

   function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
      logic ok;
      ok = (a == REG_CTRL) || (a == REG_MISC) || (a == REG_STAT);
      for (int c = 0; c < NUM_CH; c++)
         ok = ok || (a == smp_addr(c));
      return ok;
   endfunction

   function automatic logic [31:0] rd_data(input logic [ADDR_W-1:0] a);
      logic [31:0] d;
      d = 32'h0000_0000;
      if (a == REG_CTRL) d = {31'h0, en_r};
      if (a == REG_MISC) d = {24'h0, misc_r};
      if (a == REG_STAT) d = {16'h0, frames_r};
      for (int c = 0; c < NUM_CH; c++)
         if (a == smp_addr(c)) d = {8'h00, smp_r[c]};
      return d;
   endfunction

   // Two's complement word sent MSB first inside its window
   function automatic logic tx_bit(input logic [SMP_W-1:0] w, input logic [4:0] p,
                                   input logic [4:0] s, input logic [4:0] l);
      logic [4:0] k;
      k = p - s;
      return in_win(p, s, l) ? w[5'h17 - k] : 1'b0;
   endfunction

   assign fmt = fmt_of(misc_r);
   assign wl  = wl_of(misc_r);
   assign st  = start_of(fmt, wl);
   assign wr_fire = aw_have_r & w_have_r & ~bvalid_r;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awrdy_r <= 1'b1;  wrdy_r <= 1'b1;  aw_have_r <= 1'b0;  w_have_r <= 1'b0;
         bvalid_r <= 1'b0; bresp_r <= RESP_OKAY; awaddr_r <= '0;
         wdata_r <= 32'h0000_0000; wstrb_r <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid & awrdy_r)
         begin
            awaddr_r <= s_axi_awaddr; aw_have_r <= 1'b1; awrdy_r <= 1'b0;
         end
         if (s_axi_wvalid & wrdy_r)
         begin
            wdata_r <= s_axi_wdata; wstrb_r <= s_axi_wstrb; w_have_r <= 1'b1; wrdy_r <= 1'b0;
         end
         if (wr_fire)
         begin
            bvalid_r <= 1'b1; aw_have_r <= 1'b0; w_have_r <= 1'b0;
            bresp_r  <= addr_ok(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid_r & s_axi_bready)
         begin
            bvalid_r <= 1'b0; awrdy_r <= 1'b1; wrdy_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         en_r <= 1'b0;  misc_r <= MISC_RST;
         for (int c = 0; c < NUM_CH; c++) smp_r[c] <= '0;
      end
      else if (wr_fire)
      begin
         if ((awaddr_r == REG_CTRL) && wstrb_r[0]) en_r <= wdata_r[0];
         if ((awaddr_r == REG_MISC) && wstrb_r[0]) misc_r <= wdata_r[7:0];
         for (int c = 0; c < NUM_CH; c++)
            if (awaddr_r == smp_addr(c))
               for (int b = 0; b < 3; b++)
                  if (wstrb_r[b]) smp_r[c][8*b +: 8] <= wdata_r[8*b +: 8];
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arrdy_r <= 1'b1; rvalid_r <= 1'b0; rdata_r <= 32'h0000_0000; rresp_r <= RESP_OKAY;
      end
      else if (s_axi_arvalid & arrdy_r)
      begin
         arrdy_r <= 1'b0; rvalid_r <= 1'b1; rdata_r <= rd_data(s_axi_araddr);
         rresp_r <= addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rvalid_r & s_axi_rready)
      begin
         rvalid_r <= 1'b0; arrdy_r <= 1'b1;
      end
   end

   // Master clock is aclk/2; bit and frame clocks are divided from it in step
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         mclk_r <= 1'b0; sclk_r <= 1'b0; div_r <= 4'h0;
      end
      else
      begin
         mclk_r <= ~mclk_r;
         div_r  <= (div_r == DIV_LAST) ? 4'h0 : div_r + 4'h1;
         if (div_r == DIV_LAST) sclk_r <= ~sclk_r;
      end
   end

   assign fall    = sclk_r & (div_r == DIV_LAST);
   assign fb      = multi_of(fmt) ? FRAME_MULTI : FRAME_STEREO;
   assign bit_nxt = (bit_r >= fb - 8'h01) ? 8'h00 : bit_r + 8'h01;

   always_comb
   begin
      sd_nxt = 3'h0;
      word   = '0;
      ch     = 3'h0;
      if (multi_of(fmt))
         lr_nxt = (fmt == FMT_TDM) ? (bit_nxt == 8'h00) : (bit_nxt < FRAME_HALF);
      else
         lr_nxt = bit_nxt[5] ? ~left_lvl(fmt) : left_lvl(fmt);
      for (int n = 0; n < NUM_LANES; n++)
      begin
         ch   = multi_of(fmt) ? bit_nxt[7:5] : (bit_nxt[5] ? 3'(n + NUM_LANES) : 3'(n));
         word = (bit_nxt == 8'h00) ? smp_r[ch] : tx_r[ch];
         if ((!multi_of(fmt) || n == 0) && (ch < 3'(NUM_CH)))
            sd_nxt[n] = en_r & tx_bit(word, bit_nxt[4:0], st, wl);
      end
   end

   // Data and frame clock change on the falling bit-clock edge, stable at the rise
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bit_r <= 8'h00; lr_r <= 1'b0; sd_r <= 3'h0; frames_r <= 16'h0000;
         for (int c = 0; c < NUM_CH; c++) tx_r[c] <= '0;
      end
      else if (fall)
      begin
         bit_r <= bit_nxt;
         lr_r  <= lr_nxt;
         sd_r  <= sd_nxt;
         if (bit_nxt == 8'h00)
         begin
            frames_r <= frames_r + 16'h0001;
            for (int c = 0; c < NUM_CH; c++) tx_r[c] <= smp_r[c];
         end
      end
   end

   assign link.audio_master_clock_in = mclk_r;
   assign link.bit_clock_in          = sclk_r;
   assign link.frame_clock_in        = lr_r;
   assign link.serial_data_in_1      = sd_r[0];
   assign link.serial_data_in_2      = sd_r[1];
   assign link.serial_data_in_3      = sd_r[2];
   assign link.misc_configuration    = misc_r;
   assign s_axi_awready = awrdy_r;
   assign s_axi_wready  = wrdy_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = arrdy_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;
endmodule // mai_host

// File: verilog/mai_dev.sv
// Audio input port end: deserialises three data lines into six output channels.
// Assumes a slave link whose clocks all come from the far end.
//
// Contract
// - Three stereo inputs, I2S, LJ, RJ framing
// - Slave only: all link clocks are inputs
// - Far end runs frame clock at sample rate
// - Sample on bit clock, derived from master
// - Format chosen by misc configuration register
// - Two's complement words, MSB first
// - One-line modes: six channels on line one
// - TDM: six channels demultiplexed from line one
// - Stereo: line n feeds An left, Bn right
// - Six formats, word lengths sixteen to twenty-four
// - I2S MSB one bit after frame edge
// - I2S data captured on rising bit clock
// - I2S: frame clock low left, high right
// - Detect master to frame clock ratio
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module mai_dev
  (
   input  logic                         aresetn,
   mai_link_if.dev                      link,
   output logic [mai_pkg::SMP_W-1:0]    out_channel_a1,
   output logic [mai_pkg::SMP_W-1:0]    out_channel_a2,
   output logic [mai_pkg::SMP_W-1:0]    out_channel_a3,
   output logic [mai_pkg::SMP_W-1:0]    out_channel_b1,
   output logic [mai_pkg::SMP_W-1:0]    out_channel_b2,
   output logic [mai_pkg::SMP_W-1:0]    out_channel_b3,
   output logic [mai_pkg::NUM_CH-1:0]   out_valid,
   output logic                         frame_error,
   output logic [mai_pkg::NUM_LANES-1:0] lane_active,
   output logic [mai_pkg::RATIO_W-1:0]  mclk_ratio,
   output logic                         ratio_locked
  );
   import mai_pkg::*;

   logic                 bclk;
   logic                 rst_s1_r;
   logic                 rst_s2_r;
   logic [7:0]           cfg_s1_r;
   logic [7:0]           cfg_s2_r;
   mai_fmt_e             fmt_r;
   logic [4:0]           wl_r;
   logic [4:0]           st_r;
   logic                 multi_r;
   logic                 left_lvl_r;
   logic                 lr_prev_r;
   logic                 seen_r;
   logic [7:0]           idx_r;
   logic [7:0]           idx_nxt;
   logic                 start_nxt;
   logic [4:0]           pos;
   logic [2:0]           slot;
   logic                 win;
   logic                 left;
   logic [NUM_LANES-1:0] sd;
   logic [SMP_W-1:0]     sh_r   [NUM_LANES];
   logic [SMP_W-1:0]     sh_nxt [NUM_LANES];
   logic [SMP_W-1:0]     smp_r  [NUM_CH];
   logic [NUM_CH-1:0]    vld_nxt;
   logic [NUM_CH-1:0]    vld_r;
   logic                 err_r;
   logic [NUM_LANES-1:0] act_seen_r;
   logic [NUM_LANES-1:0] act_r;

   // Left-aligns a received word so shorter lengths read as the same scale
   function automatic logic [SMP_W-1:0] align(input logic [SMP_W-1:0] w,
                                              input logic [4:0]       l);
      return w << (5'h18 - l);
   endfunction

   // The port runs on the far end's bit clock; only the ratio detector runs on its master clock
   assign bclk = link.bit_clock_in;

   always_ff @(posedge bclk or negedge aresetn)
   begin
      if (!aresetn)
         {rst_s1_r, rst_s2_r} <= 2'b00;
      else
         {rst_s1_r, rst_s2_r} <= {1'b1, rst_s1_r};
   end

   // Configuration is quasi-static; once a frame start is seen, a change takes effect only at frame boundaries
   always_ff @(posedge bclk)
   begin
      if (!rst_s2_r)
      begin
         cfg_s1_r <= MISC_RST;
         cfg_s2_r <= MISC_RST;
      end
      else
      begin
         cfg_s1_r <= link.misc_configuration;
         cfg_s2_r <= cfg_s1_r;
      end
   end

   always_ff @(posedge bclk)
   begin
      if (!rst_s2_r)
      begin
         fmt_r      <= fmt_of(MISC_RST);
         wl_r       <= wl_of(MISC_RST);
         st_r       <= start_of(fmt_of(MISC_RST), wl_of(MISC_RST));
         multi_r    <= multi_of(fmt_of(MISC_RST));
         left_lvl_r <= left_lvl(fmt_of(MISC_RST));
      end
      else if (start_nxt || !seen_r)
      begin
         fmt_r      <= fmt_of(cfg_s2_r);
         wl_r       <= wl_of(cfg_s2_r);
         st_r       <= start_of(fmt_of(cfg_s2_r), wl_of(cfg_s2_r));
         multi_r    <= multi_of(fmt_of(cfg_s2_r));
         left_lvl_r <= left_lvl(fmt_of(cfg_s2_r));
      end
   end

   always_comb
   begin
      sd = {link.serial_data_in_3, link.serial_data_in_2, link.serial_data_in_1};
      if (multi_r)
         sd[NUM_LANES-1:1] = '0;
      // Multi-slot frames start on the rising frame clock, stereo on either edge
      if (multi_r)
         start_nxt = link.frame_clock_in & ~lr_prev_r;
      else
         start_nxt = link.frame_clock_in ^ lr_prev_r;
      idx_nxt = start_nxt ? 8'h00 : idx_r + 8'h01;
      pos     = idx_nxt[4:0];
      slot    = idx_nxt[7:5];
      win     = in_win(pos, st_r, wl_r);
      left    = (link.frame_clock_in == left_lvl_r);
      for (int n = 0; n < NUM_LANES; n++)
         sh_nxt[n] = win ? {sh_r[n][SMP_W-2:0], sd[n]} : sh_r[n];
   end

   always_comb
   begin
      vld_nxt = '0;
      if (seen_r && (pos == SLOT_LAST))
      begin
         if (multi_r)
         begin
            if (slot < 3'(NUM_CH))
               vld_nxt[slot] = 1'b1;
         end
         else
         begin
            for (int n = 0; n < NUM_LANES; n++)
               if (left)
                  vld_nxt[n] = 1'b1;
               else
                  vld_nxt[n + NUM_LANES] = 1'b1;
         end
      end
   end

   // Frame position tracking, sampled on the rising bit clock
   always_ff @(posedge bclk)
   begin
      if (!rst_s2_r)
      begin
         lr_prev_r <= 1'b0;
         idx_r     <= 8'h00;
         seen_r    <= 1'b0;
      end
      else
      begin
         lr_prev_r <= link.frame_clock_in;
         idx_r     <= idx_nxt;
         if (start_nxt)
            seen_r <= 1'b1;
      end
   end

   always_ff @(posedge bclk)
   begin
      if (!rst_s2_r)
      begin
         for (int n = 0; n < NUM_LANES; n++)
            sh_r[n] <= '0;
      end
      else
      begin
         for (int n = 0; n < NUM_LANES; n++)
            sh_r[n] <= sh_nxt[n];
      end
   end

   // Sample delivery; multi-slot modes take every channel from the first line
   always_ff @(posedge bclk)
   begin
      if (!rst_s2_r)
      begin
         for (int c = 0; c < NUM_CH; c++)
            smp_r[c] <= '0;
         vld_r <= '0;
      end
      else
      begin
         vld_r <= vld_nxt;
         for (int c = 0; c < NUM_CH; c++)
            if (vld_nxt[c])
               smp_r[c] <= align(multi_r ? sh_nxt[0] : sh_nxt[c % NUM_LANES], wl_r);
      end
   end

   // A frame of the wrong length is flagged; its words are still delivered
   always_ff @(posedge bclk)
   begin
      if (!rst_s2_r)
         err_r <= 1'b0;
      else if (start_nxt && seen_r)
         err_r <= multi_r ? (idx_r != FRAME_MULTI - 8'h01) : (idx_r[4:0] != SLOT_LAST);
      else
         err_r <= 1'b0;
   end

   // A line counts as active if it carried a one during the last frame; multi-slot modes watch only the first line
   always_ff @(posedge bclk)
   begin
      if (!rst_s2_r)
      begin
         act_seen_r <= '0;
         act_r      <= '0;
      end
      else if (start_nxt && (multi_r || link.frame_clock_in))
      begin
         act_r      <= act_seen_r | sd;
         act_seen_r <= '0;
      end
      else
         act_seen_r <= act_seen_r | sd;
   end

   mai_ratio mai_ratio_inst
     (
      .mclk           (link.audio_master_clock_in),
      .aresetn        (aresetn),
      .frame_clock_in (link.frame_clock_in),
      .ratio          (mclk_ratio),
      .locked         (ratio_locked)
     );

   assign out_channel_a1 = smp_r[0];
   assign out_channel_a2 = smp_r[1];
   assign out_channel_a3 = smp_r[2];
   assign out_channel_b1 = smp_r[3];
   assign out_channel_b2 = smp_r[4];
   assign out_channel_b3 = smp_r[5];
   assign out_valid      = vld_r;
   assign frame_error    = err_r;
   assign lane_active    = act_r;
endmodule // mai_dev

// File: dv/mai_link_checker.sv
// Assertions on the serial audio wires between the two link ends.
// Assumes the host's default bit clock divider and one shared reset.
`timescale 1ns/10ps
module mai_link_checker
  (
   input logic       aresetn,
   input logic       frame_clock_in,
   input logic       bit_clock_in,
   input logic       audio_master_clock_in,
   input logic       serial_data_in_1,
   input logic       serial_data_in_2,
   input logic       serial_data_in_3,
   input logic [7:0] misc_configuration
  );
   import mai_pkg::*;
   logic [8:0] age_r;
   logic [2:0] fm;
   logic       fr, ster, i2s, lj_i2s, rj, ol, tdm;
   default clocking @(posedge bit_clock_in);
   endclocking
   default disable iff (!aresetn);
   // The host applies a format change at once, even mid-frame, so judge after a long quiet spell
   always_ff @(posedge bit_clock_in)
      if (!aresetn || $changed(misc_configuration))
         age_r <= 9'h000;
      else if (!age_r[8])
         age_r <= age_r + 9'h001;
   assign fm = misc_configuration[2:0];
   assign fr = frame_clock_in;
   assign ster = age_r[8] && (fm < 3'h3);
   assign i2s = ster && (fm == 3'(FMT_I2S));
   assign lj_i2s = ster && (fm != 3'(FMT_RJ));
   assign rj = age_r[8] && (fm == 3'(FMT_RJ));
   assign ol = age_r[8] && ((fm == 3'(FMT_OL1)) || (fm == 3'(FMT_OL2)));
   assign tdm = age_r[8] && (fm == 3'(FMT_TDM));
   lead_zero_a:
      assert property (i2s && $changed(fr) |->
         {serial_data_in_1, serial_data_in_2, serial_data_in_3} == 3'h0)
         else $error("data busy in the first bit of a slot");
   tail_zero_a:
      assert property (lj_i2s && $changed(fr) |-> !$past(serial_data_in_1))
         else $error("data busy in the last bit of a slot");
   rj_lead_a:
      assert property (rj && $changed(fr) |-> !serial_data_in_1 [*8])
         else $error("right justified word starts too early");
   stereo_half_a:
      assert property (ster && $changed(fr) |=> $stable(fr) [*8])
         else $error("stereo frame half too short");
   tdm_pulse_a:
      assert property (tdm && $rose(fr) |=> !fr [*8])
         else $error("tdm frame pulse too long");
   oneline_high_a:
      assert property (ol && $rose(fr) |=> fr [*8])
         else $error("one line frame high part too short");
   oneline_low_a:
      assert property (ol && $fell(fr) |=> !fr [*8])
         else $error("one line frame low part too short");
   sclk_rate_a:
      assert property (@(posedge audio_master_clock_in) disable iff (!aresetn)
         $past(aresetn, 4) |-> $changed(bit_clock_in))
         else $error("bit clock not locked to master clock");
   cover property (i2s && $changed(fr));
   cover property (tdm && $rose(fr));
   cover property (ol && $fell(fr));
endmodule // mai_link_checker

// File: dv/multichannel_audio_serial_input_test.sv
// Bench: host end drives the link into the device end; samples go in over AXI4-Lite.
// Assumes default host divider; reset is held long enough for the bit clock sync.
`timescale 1ns/10ps
module multichannel_audio_serial_input_test;
   import mai_pkg::*;
   logic               aclk = 1'b0;
   logic               aresetn;
   logic [7:0]         awaddr = 8'h00, araddr = 8'h00;
   logic [31:0]        wdata = 32'h0, rdata;
   logic               awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
   logic               rready = 1'b0, awready, wready, bvalid, arready, rvalid;
   logic [1:0]         bresp, rresp;
   logic [23:0]        och [6];
   logic [6:0]         ovld;
   logic [3:0]         link_stat;
   logic [RATIO_W-1:0] ratio;
   int                 err_total = 0, n_compared = 0, cyc = 0;
   int                 vcnt [7] = '{default: 0};
   mai_link_if link_i ();
   mai_host mai_host_inst (.aclk(aclk), .aresetn(aresetn), .link(link_i),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   mai_dev mai_dev_inst (.aresetn(aresetn), .link(link_i), .out_channel_a1(och[0]),
      .out_channel_a2(och[1]), .out_channel_a3(och[2]), .out_channel_b1(och[3]),
      .out_channel_b2(och[4]), .out_channel_b3(och[5]), .out_valid(ovld[5:0]),
      .frame_error(ovld[6]), .lane_active(link_stat[2:0]), .mclk_ratio(ratio),
      .ratio_locked(link_stat[3]));
   mai_link_checker mai_link_checker_inst (.aresetn(aresetn),
      .frame_clock_in(link_i.frame_clock_in), .bit_clock_in(link_i.bit_clock_in),
      .audio_master_clock_in(link_i.audio_master_clock_in),
      .serial_data_in_1(link_i.serial_data_in_1), .serial_data_in_2(link_i.serial_data_in_2),
      .serial_data_in_3(link_i.serial_data_in_3),
      .misc_configuration(link_i.misc_configuration));
   initial
      forever #20 aclk = ~aclk;
   always @(posedge link_i.bit_clock_in)
      for (int c = 0; c < 7; c++)
         vcnt[c] += int'(ovld[c]);
   task automatic summarize();
      if (err_total == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   always @(posedge aclk)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         err_total++;
         summarize();
      end
   end
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end
      while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arready)
            arvalid <= 1'b0;
      end
      while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   task automatic reg_map();
      logic [31:0] d;
      logic [1:0]  r;
      rd(REG_MISC, d, r);
      chk(d[23:0], 24'(MISC_RST));
      rd(8'hFC, d, r);
      chk(24'(r), 24'(RESP_SLVERR));
      wr(8'hFC, 32'h0, r);
      chk(24'(r), 24'(RESP_SLVERR));
      wr(REG_CTRL, 32'h1, r);
   endtask
   // Word length cycles 24, 20, 16 with the format, so each mask is seen
   task automatic run_fmt(input int f);
      logic [1:0] r;
      int         k;
      int         v0 [7];
      k = f % 3;
      wr(REG_MISC, 32'(k * 16 + f), r);
      for (int c = 0; c < 6; c++)
         wr(8'(REG_SMP0 + 8'(c * 4)), {8'h00, 4'(c * 3), 4'(f), 16'hC3A5}, r);
      repeat (2400) @(posedge aclk);
      v0 = vcnt;
      repeat ((f < 3) ? 768 : 2304) @(posedge aclk);
      for (int c = 0; c < 6; c++)
      begin
         chk(24'(vcnt[c] - v0[c]), 24'h000003);
         chk(och[c], {4'(c * 3), 4'(f), 16'hC3A5} & (24'hFFFFFF << (k * 4)));
      end
      chk(24'(vcnt[6] - v0[6]), 24'h000000);
      chk(24'(link_stat), (f < 3) ? 24'h00000F : 24'h000009);
      chk(24'(ratio), (f < 3) ? 24'h000080 : 24'h000180);
   endtask
   initial
   begin
      aresetn <= 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      reg_map();
      run_fmt(0);
      run_fmt(1);
      run_fmt(2);
      run_fmt(3);
      run_fmt(4);
      run_fmt(5);
      summarize();
   end
endmodule // multichannel_audio_serial_input_test
